// ==== design/cmcs_bank.sv ====
// Status and command word bank of one character-mode serial channel
`timescale 1ns/1ns
module cmcs_bank
    import cmcs_pkg::*;
#(
    parameter bit EXTENDED = 1'b1
) (
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_b_in,
    // Memory word port
    input  wire logic [ADDR_W-1:0] word_addr_in,
    input  wire logic              word_wr_in,
    input  wire logic [WORD_W-1:0] word_wdata_in,
    output logic      [WORD_W-1:0] word_rdata_out,
    // Output word 0
    input  wire logic              out_word_wr_in,
    input  wire logic [WORD_W-1:0] out_word_wdata_in,
    output logic      [WORD_W-1:0] output_command_word_out,
    // Explicit exchange requests
    input  wire logic              status_read_request_in,
    input  wire logic              command_write_request_in,
    input  wire logic              adjust_request_in,
    // Channel events and configuration
    input  wire logic              tx_anomaly_in,
    input  wire logic              rx_anomaly_in,
    input  wire logic [7:0]        fault_live_in,
    input  wire logic              char_mode_cfg_in,
    // Modem pins
    input  wire logic              cts_pin_in,
    input  wire logic              dcd_pin_in,
    input  wire logic              dsr_pin_in,
    output logic                   dtr_out,
    // Status and actions
    output logic                   channel_error_flag_out,
    output logic      [WORD_W-1:0] modem_input_lines_out,
    output logic                   reboot_out,
    output logic                   abort_all_transfers_out
);

    // ==================================================
    // Declarations
    // ==================================================
    logic [WORD_W-1:0]   tx_anomaly_count_reg;
    logic [WORD_W-1:0]   rx_anomaly_count_reg;
    logic [WORD_W-1:0]   channel_command_word_reg;
    logic [WORD_W-1:0]   channel_fault_word_reg;
    logic [WORD_W-1:0]   link_protocol_id_reg;
    logic [NUM_XFER-1:0] exchange_outcome_reg;
    logic [NUM_XFER-1:0] xfer_busy;
    logic [NUM_XFER-1:0] xfer_done;
    logic [NUM_XFER-1:0] xfer_req;
    logic [NUM_XFER-1:0] xfer_fail;
    logic [2:0]          modem_level;
    logic                abort_edge;
    logic                cmd_apply;
    logic                clr_counters;
    logic                status_read_busy;
    logic                command_xfer_busy;
    logic                adjust_xfer_busy;
    logic                status_read_failed;
    logic                adjust_xfer_failed;
    logic [WORD_W-1:0]   rdata_next;

    assign xfer_req          = {adjust_request_in, command_write_request_in, status_read_request_in};
    assign status_read_busy  = xfer_busy[XFER_STATUS];
    assign command_xfer_busy = xfer_busy[XFER_COMMAND];
    assign adjust_xfer_busy  = xfer_busy[XFER_ADJUST];
    assign status_read_failed = exchange_outcome_reg[XFER_STATUS];
    assign adjust_xfer_failed = exchange_outcome_reg[XFER_ADJUST];

    // ==================================================
    // Output word 0: store, reboot code, abort edge
    // ==================================================
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            output_command_word_out <= WORD_RST;
        end else if (out_word_wr_in) begin
            output_command_word_out <= out_word_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reboot_out <= 1'b0;
        end else begin
            reboot_out <= out_word_wr_in && (out_word_wdata_in == REBOOT_CODE);
        end
    end

    // Edge taken from the write itself so a rewrite of 1 over 1 does not abort
    assign abort_edge = EXTENDED && out_word_wr_in && out_word_wdata_in[ABORT_BIT]
                        && !output_command_word_out[ABORT_BIT];

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            abort_all_transfers_out <= 1'b0;
        end else begin
            abort_all_transfers_out <= abort_edge;
        end
    end

    // ==================================================
    // Explicit exchange slots
    // ==================================================
    for (genvar i = 0; i < NUM_XFER; i++) begin : g_xfer
        cmcs_xfer_e        state_reg;
        logic [XCNT_W-1:0] cnt_reg;

        always_ff @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                state_reg <= CMCS_IDLE;
                cnt_reg   <= '0;
            end else begin
                unique case (state_reg)
                    CMCS_IDLE: begin
                        if (xfer_req[i] && !abort_edge) begin
                            state_reg <= CMCS_BUSY;
                            cnt_reg   <= XCNT_W'(XFER_CYCLES);
                        end
                    end
                    CMCS_BUSY: begin
                        if (xfer_done[i]) begin
                            state_reg <= CMCS_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                endcase
            end
        end

        assign xfer_busy[i] = (state_reg == CMCS_BUSY);
        assign xfer_done[i] = xfer_busy[i] && (abort_edge || cnt_reg == XCNT_W'(1));
    end

    // Abort fails every open exchange; the adjust exchange is not served on the extended variant
    assign xfer_fail = {NUM_XFER{abort_edge}} | {EXTENDED, 2'b00};

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            exchange_outcome_reg <= '0;
        end else begin
            for (int k = 0; k < NUM_XFER; k++) begin
                if (xfer_done[k]) begin
                    exchange_outcome_reg[k] <= xfer_fail[k];
                end
            end
        end
    end

    // ==================================================
    // Status snapshot taken by a completed status read, and the error flag that follows the live faults
    // ==================================================
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_fault_word_reg <= WORD_RST;
            link_protocol_id_reg   <= WORD_RST;
        end else if (xfer_done[XFER_STATUS] && !abort_edge) begin
            channel_fault_word_reg <= {8'h00, fault_live_in};
            link_protocol_id_reg   <= {8'h00, char_mode_cfg_in ? PROTO_CHAR_MODE : PROTO_NONE};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_error_flag_out <= 1'b0;
        end else begin
            channel_error_flag_out <= |fault_live_in;
        end
    end

    // ==================================================
    // Command word and its application
    // ==================================================
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_command_word_reg <= WORD_RST;
        end else if (word_wr_in && word_addr_in == IDX_COMMAND) begin
            channel_command_word_reg <= word_wdata_in;
        end
    end

    assign cmd_apply    = xfer_done[XFER_COMMAND] && !abort_edge;
    assign clr_counters = cmd_apply && channel_command_word_reg[CMD_CLR_CNT_BIT];

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dtr_out <= 1'b0;
        end else if (cmd_apply) begin
            if (channel_command_word_reg[CMD_DTR_OFF_BIT]) begin
                dtr_out <= 1'b0;
            end else if (channel_command_word_reg[CMD_DTR_ON_BIT]) begin
                dtr_out <= 1'b1;
            end
        end
    end

    // ==================================================
    // Anomaly counters; an event in the clearing cycle survives
    // ==================================================
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_anomaly_count_reg <= WORD_RST;
        end else if (clr_counters) begin
            tx_anomaly_count_reg <= {15'h0000, tx_anomaly_in};
        end else if (tx_anomaly_in && tx_anomaly_count_reg != COUNT_MAX) begin
            tx_anomaly_count_reg <= tx_anomaly_count_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_anomaly_count_reg <= WORD_RST;
        end else if (clr_counters) begin
            rx_anomaly_count_reg <= {15'h0000, rx_anomaly_in};
        end else if (rx_anomaly_in && rx_anomaly_count_reg != COUNT_MAX) begin
            rx_anomaly_count_reg <= rx_anomaly_count_reg + 1'b1;
        end
    end

    // ==================================================
    // Modem inputs
    // ==================================================
    cmcs_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .pin_in      ({dsr_pin_in, cts_pin_in, dcd_pin_in}),
        .level_out   (modem_level)
    );

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            modem_input_lines_out <= WORD_RST;
        end else begin
            modem_input_lines_out                <= WORD_RST;
            modem_input_lines_out[MODEM_DCD_BIT] <= EXTENDED && modem_level[0];
            modem_input_lines_out[MODEM_CTS_BIT] <= modem_level[1];
            modem_input_lines_out[MODEM_DSR_BIT] <= EXTENDED && modem_level[2];
        end
    end

    // ==================================================
    // Word read port, one cycle latency
    // ==================================================
    always_comb begin
        rdata_next = WORD_RST;
        case (word_addr_in)
            IDX_ACTIVITY:   rdata_next = {13'h0000, xfer_busy};
            IDX_OUTCOME:    rdata_next = {13'h0000, exchange_outcome_reg};
            IDX_FAULT:      rdata_next = channel_fault_word_reg;
            IDX_PROTOCOL:   rdata_next = link_protocol_id_reg;
            IDX_TX_ANOMALY: rdata_next = tx_anomaly_count_reg;
            IDX_RX_ANOMALY: rdata_next = rx_anomaly_count_reg;
            IDX_COMMAND:    rdata_next = channel_command_word_reg;
            default:        rdata_next = WORD_RST;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            word_rdata_out <= WORD_RST;
        end else begin
            word_rdata_out <= rdata_next;
        end
    end

    // ==================================================
    // Assertions
    // ==================================================
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_reboot_code: assert property (
        reboot_out == $past(out_word_wr_in && out_word_wdata_in == REBOOT_CODE))
        else $error("reboot pulse does not match code write");

    a_tx_count_step: assert property (
        !clr_counters && tx_anomaly_in && tx_anomaly_count_reg != COUNT_MAX
        |=> tx_anomaly_count_reg == $past(tx_anomaly_count_reg) + 16'h0001)
        else $error("tx anomaly counter failed to step");

    a_rx_count_hold: assert property (
        !clr_counters && !rx_anomaly_in |=> $stable(rx_anomaly_count_reg))
        else $error("rx anomaly counter moved without an event");

    a_counter_clear: assert property (
        clr_counters && !tx_anomaly_in && !rx_anomaly_in
        |=> tx_anomaly_count_reg == 16'h0000 && rx_anomaly_count_reg == 16'h0000)
        else $error("counters not cleared by command");

    a_error_flag: assert property (
        ##1 channel_error_flag_out == $past(|fault_live_in))
        else $error("channel error flag does not follow faults");

    a_modem_cts: assert property (
        modem_level[1] |-> ##1 modem_input_lines_out[MODEM_CTS_BIT])
        else $error("CTS level not reflected in input word");

    a_busy_length: assert property (
        $rose(status_read_busy) && !abort_edge ##1 !abort_edge [*2]
        |=> status_read_busy ##1 !status_read_busy)
        else $error("status read busy time differs from its exchange time");

    a_done_report: assert property (
        xfer_done[XFER_COMMAND] |=> !command_xfer_busy && exchange_outcome_reg[XFER_COMMAND] == $past(abort_edge))
        else $error("command exchange report not updated at completion");

    a_protocol_id: assert property (
        xfer_done[XFER_STATUS] && !abort_edge && char_mode_cfg_in
        |=> link_protocol_id_reg[7:0] == PROTO_CHAR_MODE)
        else $error("protocol word low byte wrong in character mode");

    a_dtr_command: assert property (
        cmd_apply && channel_command_word_reg[CMD_DTR_ON_BIT] && !channel_command_word_reg[CMD_DTR_OFF_BIT]
        |=> dtr_out)
        else $error("DTR not raised by command");

    a_dtr_no_act: assert property (
        !cmd_apply |=> $stable(dtr_out))
        else $error("DTR changed without a command exchange");

    a_abort_all: assert property (
        abort_edge |=> xfer_busy == 3'b000 && abort_all_transfers_out)
        else $error("abort left an exchange running");

    a_fault_snap: assert property (
        !(xfer_done[XFER_STATUS] && !abort_edge) |=> $stable(channel_fault_word_reg))
        else $error("fault word changed without a status read");

    c_status_read: cover property (
        $rose(status_read_busy) ##[1:8] $fell(status_read_busy) && !status_read_failed);

    c_adjust_fail: cover property (
        $rose(adjust_xfer_busy) ##[1:8] adjust_xfer_failed);

    c_clear_counters: cover property (
        tx_anomaly_count_reg != 16'h0000 ##[1:50] clr_counters);

    c_abort: cover property (
        command_xfer_busy && abort_edge);

endmodule

// ==== design/cmcs_pkg.sv ====
// Package of offsets, field positions, codes and timing for the character-mode channel bank
package cmcs_pkg;

    // ==================================================
    // Word width and memory word indices
    // ==================================================
    localparam int          WORD_W          = 16;
    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  IDX_ACTIVITY    = 5'h00;
    localparam logic [4:0]  IDX_OUTCOME     = 5'h01;
    localparam logic [4:0]  IDX_FAULT       = 5'h02;
    localparam logic [4:0]  IDX_PROTOCOL    = 5'h03;
    localparam logic [4:0]  IDX_TX_ANOMALY  = 5'h04;
    localparam logic [4:0]  IDX_RX_ANOMALY  = 5'h05;
    localparam logic [4:0]  IDX_COMMAND     = 5'h18;

    // ==================================================
    // Field positions
    // ==================================================
    localparam int          XFER_STATUS     = 0;
    localparam int          XFER_COMMAND    = 1;
    localparam int          XFER_ADJUST     = 2;
    localparam int          NUM_XFER        = 3;
    localparam int          CMD_CLR_CNT_BIT = 0;
    localparam int          CMD_DTR_ON_BIT  = 8;
    localparam int          CMD_DTR_OFF_BIT = 9;
    localparam int          MODEM_DCD_BIT   = 0;
    localparam int          MODEM_CTS_BIT   = 2;
    localparam int          MODEM_DSR_BIT   = 3;
    localparam int          ABORT_BIT       = 0;
    localparam int          FAULT_BITS      = 8;

    // ==================================================
    // Codes and reset values
    // ==================================================
    localparam logic [15:0] REBOOT_CODE     = 16'hdead;
    localparam logic [7:0]  PROTO_CHAR_MODE = 8'h03;
    localparam logic [7:0]  PROTO_NONE      = 8'h00;
    localparam logic [15:0] WORD_RST        = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hffff;

    // ==================================================
    // Timing
    // ==================================================
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          XFER_TIME_NS    = 40;
    localparam int          XFER_CYCLES     = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          XCNT_W          = 4;

    // ==================================================
    // Exchange slot states
    // ==================================================
    typedef enum logic [1:0] {
        CMCS_IDLE = 2'b01,
        CMCS_BUSY = 2'b10
    } cmcs_xfer_e;

endpackage

// ==== design/cmcs_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module cmcs_sync
    import cmcs_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    // ==================================================
    // Per-bit stages
    // ==================================================
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;

        always_ff @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
            end else begin
                s1_reg <= pin_in[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
            end
        end

        always_ff @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                level_out[i] <= 1'b0;
            end else if (s2_reg == s3_reg) begin
                level_out[i] <= s3_reg;
            end
        end
    end

endmodule

// ==== test/char_mode_channel_status_test.sv ====
// Self-checking bench of the character-mode channel status bank
`timescale 1ns/1ns
module char_mode_channel_status_test;
    import cmcs_pkg::*;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [4:0]        addr = 5'h00;
    logic              wr = 1'b0;
    logic [15:0]       wdata = 16'h0000;
    logic [15:0]       rdata;
    logic              ow_wr = 1'b0;
    logic [15:0]       ow_data = 16'h0000;
    logic [15:0]       ocw;
    logic [2:0]        req = 3'h0;
    logic              txa = 1'b0;
    logic              rxa = 1'b0;
    logic [7:0]        fault = 8'h00;
    logic              cmode = 1'b1;
    logic              cts, dcd, dsr, dtr, err, reboot, abort;
    logic [15:0]       modem;
    int                n_mismatch = 0;
    int                n_compared = 0;

    always #5 clk = ~clk;

    cmcs_bank #(.EXTENDED(1'b1)) DUT (
        .core_clk_in(clk), .rst_b_in(rst_b), .word_addr_in(addr), .word_wr_in(wr),
        .word_wdata_in(wdata), .word_rdata_out(rdata), .out_word_wr_in(ow_wr),
        .out_word_wdata_in(ow_data), .output_command_word_out(ocw),
        .status_read_request_in(req[0]), .command_write_request_in(req[1]), .adjust_request_in(req[2]),
        .tx_anomaly_in(txa), .rx_anomaly_in(rxa), .fault_live_in(fault), .char_mode_cfg_in(cmode),
        .cts_pin_in(cts), .dcd_pin_in(dcd), .dsr_pin_in(dsr), .dtr_out(dtr),
        .channel_error_flag_out(err), .modem_input_lines_out(modem),
        .reboot_out(reboot), .abort_all_transfers_out(abort));

    cmcs_peer peer (.core_clk_in(clk), .dtr_in(dtr), .cts_pin_out(cts), .dcd_pin_out(dcd), .dsr_pin_out(dsr));

    // ==================================================
    // Access tasks
    // ==================================================
    task automatic close_out;
        $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge clk) addr <= a;
        @(posedge clk) #1;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        rd(a);
        chk(rdata, exp);
    endtask

    task automatic wr_cmd(input logic [15:0] d);
        @(posedge clk) begin
            addr <= IDX_COMMAND;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask

    task automatic ow(input logic [15:0] d);
        @(posedge clk) begin
            ow_data <= d;
            ow_wr <= 1'b1;
        end
        @(posedge clk) ow_wr <= 1'b0;
        #1;
    endtask

    task automatic start(input int i);
        @(posedge clk) req <= 3'h1 << i;
        @(posedge clk) req <= 3'h0;
    endtask

    task automatic xfer(input int i);
        int k;
        k = 0;
        start(i);
        rdchk(IDX_ACTIVITY, 16'h0001 << i);
        while (rdata !== 16'h0000) begin
            if (k == 10) begin
                n_mismatch++;
                close_out();
            end
            rd(IDX_ACTIVITY);
            k++;
        end
    endtask

    // ==================================================
    // Test sequence
    // ==================================================
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (int j = 0; j < 6; j++) begin
            rdchk(j[4:0], 16'h0000);
        end
        rdchk(5'h07, 16'h0000);
        chk({15'h0, dtr}, 16'h0000);
        $display("test reset done");
        for (int j = 0; j < 3; j++) begin
            @(posedge clk) begin
                txa <= 1'b1;
                rxa <= (j < 2);
            end
            @(posedge clk) begin
                txa <= 1'b0;
                rxa <= 1'b0;
            end
        end
        rdchk(IDX_TX_ANOMALY, 16'h0003);
        rdchk(IDX_RX_ANOMALY, 16'h0002);
        $display("test counters done");
        wr_cmd(16'h0101);
        rdchk(IDX_COMMAND, 16'h0101);
        chk({15'h0, dtr}, 16'h0000);
        rdchk(IDX_TX_ANOMALY, 16'h0003);
        xfer(1);
        chk({15'h0, dtr}, 16'h0001);
        rdchk(IDX_TX_ANOMALY, 16'h0000);
        rdchk(IDX_RX_ANOMALY, 16'h0000);
        rdchk(IDX_OUTCOME, 16'h0000);
        wr_cmd(16'h0300);
        xfer(1);
        chk({15'h0, dtr}, 16'h0000);
        $display("test command done");
        @(posedge clk) fault <= 8'ha5;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, err}, 16'h0001);
        xfer(0);
        rdchk(IDX_FAULT, 16'h00a5);
        rdchk(IDX_PROTOCOL, 16'h0003);
        @(posedge clk) fault <= 8'h18;
        rdchk(IDX_FAULT, 16'h00a5);
        xfer(0);
        rdchk(IDX_FAULT, 16'h0018);
        @(posedge clk) fault <= 8'h00;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, err}, 16'h0000);
        xfer(2);
        rdchk(IDX_OUTCOME, 16'h0004);
        $display("test exchanges done");
        peer.set_lines(3'b001);
        repeat (8) @(posedge clk);
        #1 chk(modem, 16'h0004);
        peer.set_lines(3'b111);
        repeat (8) @(posedge clk);
        #1 chk(modem, 16'h000d);
        $display("test modem done");
        start(0);
        ow(16'h0001);
        chk({15'h0, abort}, 16'h0001);
        chk(ocw, 16'h0001);
        rdchk(IDX_ACTIVITY, 16'h0000);
        rdchk(IDX_OUTCOME, 16'h0005);
        rdchk(IDX_FAULT, 16'h0018);
        ow(16'hdead);
        chk({15'h0, reboot}, 16'h0001);
        chk({15'h0, abort}, 16'h0000);
        chk(ocw, 16'hdead);
        $display("test output word done");
        close_out();
    end
endmodule

// ==== test/cmcs_peer.sv ====
// Far-side modem peer that drives the channel's RS232 input lines
`timescale 1ns/1ns
module cmcs_peer (
    // Clock
    input  wire logic core_clk_in,
    // Line from the channel
    input  wire logic dtr_in,
    // Lines to the channel
    output logic      cts_pin_out,
    output logic      dcd_pin_out,
    output logic      dsr_pin_out
);
    logic [2:0] want_reg = 3'h0;

    // Positive line voltage is presented as a high level
    always_ff @(posedge core_clk_in) begin
        {dsr_pin_out, dcd_pin_out, cts_pin_out} <= want_reg;
    end

    task automatic set_lines(input logic [2:0] lv);
        want_reg = lv;
    endtask
endmodule
